// >>> pkg/dcc_pkg.sv
// constants, encodings and carrier types of the detector call conditioner
// assumes one 20 MHz clock and an apb register port with 12-bit addresses
package dcc_pkg;

	// ==========================================================
	// sizing
	localparam int NCAM = 2;
	localparam int ZPC = 8;
	localparam int NCALL = NCAM * ZPC;
	localparam int CNT_W = 8;
	localparam int IRQ_W = NCAM + 1;
	localparam int IDX_W = $clog2(NCALL);

	// ==========================================================
	// timing
	localparam int CLK_HZ = 20000000;
	localparam int MS_PER_S = 1000;
	localparam int TICK_MS = 1;
	localparam int FRAME_RATE_MIN = 30;
	localparam int LATENCY_MS = 112;
	localparam int PULSE_MS = 125;
	localparam int TICK_CYC_DFLT = CLK_HZ / MS_PER_S * TICK_MS;
	localparam int FRAME_TO_DFLT = CLK_HZ / FRAME_RATE_MIN;
	localparam logic [CNT_W-1:0] PULSE_TICKS = CNT_W'(PULSE_MS / TICK_MS);

	// ==========================================================
	// register map
	localparam logic [11:0] OFF_CTRL = 12'h000;
	localparam logic [11:0] OFF_STAT = 12'h004;
	localparam logic [11:0] OFF_MASK = 12'h008;
	localparam logic [11:0] OFF_LIVE = 12'h00C;
	localparam logic [11:0] OFF_CFG = 12'h040;
	localparam logic [11:0] OFF_CFG_END = 12'h080;
	localparam logic [11:0] ALIGN_MASK = 12'h003;
	localparam int WORD_SH = 2;
	localparam int CTRL_CABX_BIT = 0;
	localparam int IRQ_PWR_BIT = NCAM;

	// ==========================================================
	// encodings and carriers
	typedef enum logic [2:0] {
		TM_NONE, TM_FULL, TM_NORM, TM_EXT, TM_DLYEXT
	} dcc_tmode_t;

	typedef enum logic [1:0] {
		ZF_PRES, ZF_DPRES, ZF_PULSE, ZF_DPULSE
	} dcc_zfunc_t;

	typedef enum logic [1:0] {
		CS_IDLE, CS_DLY, CS_CALL, CS_EXT
	} dcc_cst_t;

	// one call word: mode [2:0], function [4:3], delay [12:5], extend [20:13]
	typedef struct packed {
		logic [CNT_W-1:0] ext;
		logic [CNT_W-1:0] dly;
		dcc_zfunc_t func;
		dcc_tmode_t mode;
	} dcc_cfg_t;

	localparam int CFG_W = $bits(dcc_cfg_t);

	typedef struct packed {
		logic [NCALL-1:0] occ;
		logic [NCALL-1:0] dir_ok;
	} dcc_zone_t;

	typedef struct packed {
		logic [NCAM-1:0] frame;
		logic [NCAM-1:0] fail;
	} dcc_cam_t;

endpackage

// >>> design/dcc_top.sv
// detector call conditioner: zone occupancy in, controller calls out
// assumes a front end giving per-zone occupancy, direction and frame
// strobes synchronous to pclk; registers over apb
//
// Summary of operation
// - full-time delay timer runs regardless of green
// - normal delay bypassed during green, unless cabinet
// - extend holds call after vehicle leaves
// - combined mode accepts call after delay expiry
// - combined mode holds until empty plus extend
// - re-entry during extend holds call, restarts
// - after extend drop, delay must expire again
// - zone function presence, directional, pulse, directional
// - eight zones and eight outputs per camera
// - overlapping zones evaluated each independently
// - call asserted well within 112 ms
// - camera or power fail forces constant calls
// - frame updates slower than 30/s flag failure
// - all cameras and outputs processed in parallel
// - configuration editable, takes effect live
//
// Register access over APB and the address map were left to the implementer.
`timescale 1ns/1ps
module dcc_top
	import dcc_pkg::*;
#(
	parameter int unsigned TICK_CYCLES = dcc_pkg::TICK_CYC_DFLT,
	parameter int unsigned FRAME_TO_CYCLES = dcc_pkg::FRAME_TO_DFLT
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire dcc_pkg::dcc_zone_t zone,
	input wire logic [dcc_pkg::NCALL-1:0] phase_green,
	input wire dcc_pkg::dcc_cam_t cam,
	input wire logic unit_power_fail,
	output logic [dcc_pkg::NCALL-1:0] call_out,
	output logic irq
);
	import dcc_pkg::*;

	localparam int TICK_W = $clog2(TICK_CYCLES) + 1;
	localparam int FTO_W = $clog2(FRAME_TO_CYCLES) + 1;
	localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);
	localparam logic [FTO_W-1:0] FTO_MAX = FTO_W'(FRAME_TO_CYCLES);

	// ==========================================================
	// state
	typedef struct packed {
		logic [TICK_W-1:0] tdiv;
		logic tick;
		logic [NCAM-1:0][FTO_W-1:0] fcnt;
		logic [IRQ_W-1:0] fail_prev;
		logic cabx;
		logic [IRQ_W-1:0] stat;
		logic [IRQ_W-1:0] mask;
		dcc_cfg_t [NCALL-1:0] cfg;
		dcc_cst_t [NCALL-1:0] st;
		logic [NCALL-1:0][CNT_W-1:0] cnt;
		logic [NCALL-1:0][CNT_W-1:0] pcnt;
		logic [NCALL-1:0] prev;
		logic [NCALL-1:0] call;
		logic [NCALL-1:0] out;
		logic [31:0] prdata;
		logic pslverr;
	} dcc_state_t;

	dcc_state_t r;
	dcc_state_t n;
	logic [NCALL-1:0] det;
	logic [NCAM-1:0] failv;
	logic [31:0] rdv;

	// ==========================================================
	// next state
	always_comb
	begin
		logic raw;
		logic rise;
		logic dmode;
		logic emode;
		logic inhib;
		logic hit;
		logic clr;
		logic cfg_hit;
		logic [IDX_W-1:0] idx;
		logic [IRQ_W-1:0] cur;
		raw = 1'b0;
		rise = 1'b0;
		dmode = 1'b0;
		emode = 1'b0;
		inhib = 1'b0;
		hit = 1'b0;
		clr = 1'b0;
		cfg_hit = 1'b0;
		idx = '0;
		cur = '0;
		n = r;
		det = '0;
		failv = '0;
		rdv = '0;

		// millisecond timebase for every call timer
		n.tick = 1'b0;
		if (r.tdiv == TICK_LAST)
		begin
			n.tdiv = '0;
			n.tick = 1'b1;
		end
		else
			n.tdiv = r.tdiv + 1'b1;

		// frame watchdog: a stalled front end counts as camera failure
		for (int c = 0; c < NCAM; c++)
		begin
			if (cam.frame[c])
				n.fcnt[c] = '0;
			else if (r.fcnt[c] != FTO_MAX)
				n.fcnt[c] = r.fcnt[c] + 1'b1;
			failv[c] = cam.fail[c] | (r.fcnt[c] == FTO_MAX) | unit_power_fail;
		end

		// every call runs its own copy of the same logic each cycle
		for (int i = 0; i < NCALL; i++)
		begin
			// directional functions need the direction qualifier
			raw = zone.occ[i];
			if (r.cfg[i].func == ZF_DPRES || r.cfg[i].func == ZF_DPULSE)
				raw = zone.occ[i] & zone.dir_ok[i];
			rise = raw & ~r.prev[i];
			n.prev[i] = raw;
			if (rise)
				n.pcnt[i] = PULSE_TICKS;
			else if (r.tick && r.pcnt[i] != '0)
				n.pcnt[i] = r.pcnt[i] - 1'b1;
			if (r.cfg[i].func == ZF_PULSE || r.cfg[i].func == ZF_DPULSE)
				det[i] = rise | (r.pcnt[i] != '0);
			else
				det[i] = raw;

			dmode = r.cfg[i].mode == TM_FULL || r.cfg[i].mode == TM_NORM ||
				r.cfg[i].mode == TM_DLYEXT;
			emode = r.cfg[i].mode == TM_EXT || r.cfg[i].mode == TM_DLYEXT;
			// green lifts the normal delay; the cabinet bit disables that
			inhib = r.cfg[i].mode == TM_NORM && phase_green[i] && !r.cabx;

			case (r.st[i])
				CS_IDLE:
				begin
					if (det[i])
					begin
						if (dmode && r.cfg[i].dly != '0 && !inhib)
						begin
							n.st[i] = CS_DLY;
							n.cnt[i] = r.cfg[i].dly;
						end
						else
							n.st[i] = CS_CALL;
					end
				end
				CS_DLY:
				begin
					if (!det[i])
						n.st[i] = CS_IDLE;
					else if (inhib)
						n.st[i] = CS_CALL;
					else if (r.cnt[i] == '0)
						n.st[i] = CS_CALL;
					else if (r.tick)
						n.cnt[i] = r.cnt[i] - 1'b1;
				end
				CS_CALL:
				begin
					if (!det[i])
					begin
						if (emode && r.cfg[i].ext != '0)
						begin
							n.st[i] = CS_EXT;
							n.cnt[i] = r.cfg[i].ext;
						end
						else
							n.st[i] = CS_IDLE;
					end
				end
				CS_EXT:
				begin
					if (det[i])
						n.st[i] = CS_CALL;
					else if (r.cnt[i] == '0)
						n.st[i] = CS_IDLE;
					else if (r.tick)
						n.cnt[i] = r.cnt[i] - 1'b1;
				end
				default:
					n.st[i] = CS_IDLE;
			endcase
			n.call[i] = n.st[i] == CS_CALL || n.st[i] == CS_EXT;
			n.out[i] = n.call[i] | failv[i / ZPC];
		end

		// fail onsets are the interrupt events
		cur = {unit_power_fail, cam.fail | failv[NCAM-1:0]};
		n.fail_prev = cur;

		// apb decode
		cfg_hit = paddr >= OFF_CFG && paddr < OFF_CFG_END &&
			(paddr & ALIGN_MASK) == '0;
		idx = IDX_W'((paddr - OFF_CFG) >> WORD_SH);
		hit = 1'b1;
		case (paddr)
			OFF_CTRL:
				rdv = 32'(r.cabx);
			OFF_STAT:
				rdv = 32'(r.stat);
			OFF_MASK:
				rdv = 32'(r.mask);
			OFF_LIVE:
				rdv = 32'({failv, r.out});
			default:
			begin
				hit = cfg_hit;
				if (cfg_hit)
					rdv = 32'(r.cfg[idx]);
			end
		endcase

		// read data and error are caught in setup, shown in access
		if (psel && !penable)
		begin
			n.prdata = rdv;
			n.pslverr = !hit;
		end
		if (psel && penable && hit)
		begin
			if (pwrite)
			begin
				case (paddr)
					OFF_CTRL:
						n.cabx = pwdata[CTRL_CABX_BIT];
					OFF_MASK:
						n.mask = pwdata[IRQ_W-1:0];
					OFF_STAT, OFF_LIVE:
						n.mask = r.mask;
					default:
						n.cfg[idx] = dcc_cfg_t'(pwdata[CFG_W-1:0]);
				endcase
			end
			else if (paddr == OFF_STAT)
				clr = 1'b1;
		end
		// a new event in the clearing cycle survives the clear
		n.stat = (clr ? '0 : r.stat) | (cur & ~r.fail_prev);
	end

	// ==========================================================
	// registers
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			r <= '0;
		else
			r <= n;
	end

	assign prdata = r.prdata;
	assign pslverr = r.pslverr;
	assign pready = 1'b1;
	assign call_out = r.out;
	assign irq = |(r.stat & r.mask);

	// ==========================================================
	// checks
	default clocking dcc_cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	a_power_fail_calls: assert property (
		unit_power_fail |=> call_out == '1)
		else $error("power failure did not force all calls");

	a_cam_fail_calls: assert property (
		cam.fail[0] |=> call_out[ZPC-1:0] == '1)
		else $error("camera failure did not force its calls");

	a_presence_latency: assert property (
		zone.occ[0] && r.st[0] == CS_IDLE && r.cfg[0].mode == TM_NONE &&
		r.cfg[0].func == ZF_PRES |=> call_out[0] && r.st[0] == CS_CALL)
		else $error("presence call late");

	a_extend_holds: assert property (
		r.st[0] == CS_EXT |-> r.call[0] && call_out[0])
		else $error("call dropped during extend");

	a_extend_count: assert property (
		r.st[0] == CS_CALL && !det[0] && r.cfg[0].mode == TM_DLYEXT &&
		r.cfg[0].ext != '0 |=> r.st[0] == CS_EXT &&
		r.cnt[0] == $past(r.cfg[0].ext))
		else $error("extend not loaded on zone empty");

	a_delay_first: assert property (
		$rose(r.call[0]) && r.cfg[0].mode == TM_DLYEXT &&
		$past(r.cfg[0].dly) != '0 |->
		$past(r.st[0]) == CS_DLY && $past(r.cnt[0]) == '0)
		else $error("combined call accepted before delay expiry");

	a_reentry_restart: assert property (
		r.st[0] == CS_EXT && det[0] |=> r.st[0] == CS_CALL && call_out[0])
		else $error("extend not restarted on re-entry");

	a_redelay_after: assert property (
		r.st[0] == CS_EXT && !det[0] && r.cnt[0] == '0 |=>
		r.st[0] == CS_IDLE && !r.call[0])
		else $error("extend expiry did not return to idle");

	a_full_delay_runs: assert property (
		r.st[0] == CS_DLY && r.cfg[0].mode == TM_FULL && det[0] &&
		r.tick && r.cnt[0] != '0 |=>
		r.cnt[0] == $past(r.cnt[0]) - 1'b1)
		else $error("full delay timer stalled");

	a_normal_inhibit: assert property (
		r.st[0] == CS_DLY && r.cfg[0].mode == TM_NORM && phase_green[0] &&
		!r.cabx && det[0] |=> r.st[0] == CS_CALL)
		else $error("normal delay not lifted by green");

	a_frame_watchdog: assert property (
		r.fcnt[0] == FTO_MAX |=> call_out[ZPC-1:0] == '1)
		else $error("frame timeout did not force calls");

	a_stat_sticky: assert property (
		r.stat[IRQ_PWR_BIT] &&
		!(psel && penable && !pwrite && paddr == OFF_STAT) |=>
		r.stat[IRQ_PWR_BIT])
		else $error("power fail status lost without a read");

endmodule

// >>> dv/dcc_ctrl_model.sv
// signal controller seen from the call outputs: serves phases on request
// assumes the bench asks for green per call and watches the calls itself
`timescale 1ns/1ps
module dcc_ctrl_model
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [15:0] green_req,
	input wire logic [15:0] call_out,
	output logic [15:0] phase_green,
	output logic [15:0] calls_seen
);
	// ==========================================================
	// phase timing: green follows the request one cycle late
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			phase_green <= 16'h0000;
			calls_seen <= 16'h0000;
		end
		else
		begin
			phase_green <= green_req;
			calls_seen <= calls_seen | call_out;
		end
	end
endmodule

// >>> dv/testbench.sv
// self-checking bench of the call conditioner
// assumes short tick and frame parameters so timers finish quickly
`timescale 1ns/1ps
module testbench;
	import dcc_pkg::*;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, r, s = 32'hB6D0AF26;
	logic pready, pslverr, e, irq, upf = 0;
	logic [15:0] call_out, green_req = 16'h0, phase_green, ex;
	dcc_zone_t zone = '0;
	dcc_cam_t cam = '0;
	int err_total = 0, checks = 0, fc = 0;
	dcc_top #(.TICK_CYCLES(4), .FRAME_TO_CYCLES(64)) u_dut (.pclk(pclk),
		.presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .zone(zone),
		.phase_green(phase_green), .cam(cam), .unit_power_fail(upf),
		.call_out(call_out), .irq(irq));
	dcc_ctrl_model u_ctl (.pclk(pclk), .presetn(presetn),
		.green_req(green_req), .call_out(call_out),
		.phase_green(phase_green), .calls_seen());
	always #25 pclk = ~pclk;
	// keep the frame watchdog fed well inside its limit
	always @(posedge pclk)
	begin
		fc <= fc + 1;
		cam.frame <= {2{fc[3:0] == 4'h0}};
	end
	// ==========================================================
	// helpers
	function logic [31:0] xs();
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction
	task print_verdict();
		if (err_total == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] x);
		checks++;
		if (g !== x)
		begin
			err_total++;
			$display("unexpected %0t got %h want %h", $time, g, x);
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task run(input int n);
		repeat (n) @(posedge pclk);
		#1;
	endtask
	task step(input int b, input logic v, input int n, input logic x);
		@(posedge pclk);
		zone.occ[b] <= v;
		run(n);
		chk(call_out[b], x);
	endtask
	// ==========================================================
	// sequence
	initial
	begin
		#(50 * 20000);
		err_total++;
		print_verdict();
	end
	initial
	begin
		run(16);
		presetn <= 1;
		apb(0, OFF_CTRL, 0);
		chk(r, 0);
		apb(0, OFF_STAT, 0);
		chk(r, 0);
		apb(1, OFF_CFG + 12'h024, 32'h8);
		apb(1, OFF_MASK, 32'h7);
		for (int i = 0; i < 200; i++)
		begin
			@(posedge pclk);
			zone.occ <= 16'(xs());
			zone.dir_ok <= 16'(xs());
			#1;
			if (i > 0) chk(call_out, ex);
			ex = zone.occ;
			ex[9] = ex[9] & zone.dir_ok[9];
		end
		zone.occ <= 16'h0;
		apb(1, OFF_CFG, 32'h6003);
		apb(1, OFF_CFG + 12'h004, 32'hA1);
		apb(1, OFF_CFG + 12'h008, 32'hA2);
		apb(1, OFF_CFG + 12'h00C, 32'h4044);
		green_req <= 16'h0006;
		step(0, 1, 3, 1);
		step(0, 0, 4, 1);
		run(30);
		chk(call_out[0], 0);
		step(1, 1, 6, 0);
		run(30);
		chk(call_out[1], 1);
		step(2, 1, 3, 1);
		step(3, 1, 2, 0);
		run(20);
		chk(call_out[3], 1);
		step(3, 0, 2, 1);
		step(3, 1, 2, 1);
		step(3, 0, 25, 0);
		step(3, 1, 2, 0);
		zone.occ <= 16'h0;
		run(40);
		@(posedge pclk);
		upf <= 1;
		run(2);
		chk(call_out, 16'hFFFF);
		chk(irq, 1);
		apb(0, OFF_STAT, 0);
		chk(r & 32'h4, 32'h4);
		@(posedge pclk);
		upf <= 0;
		apb(0, OFF_STAT, 0);
		chk(r, 0);
		chk(irq, 0);
		apb(0, 12'h100, 0);
		chk({e, r}, 33'h100000000);
		// camera 0 failure forces only its own eight calls
		cam.fail <= 2'b01;
		run(2);
		chk(call_out[7:0], 8'hFF);
		chk(call_out[15:8], 8'h00);
		@(posedge pclk);
		cam.fail <= 2'b00;
		run(2);
		chk(call_out, 16'h0000);
		// cabinet exception keeps the normal delay running in green
		apb(1, OFF_CTRL, 32'h1);
		step(2, 1, 6, 0);
		run(30);
		chk(call_out[2], 1);
		// pulse function: call ends although the zone stays occupied
		apb(1, OFF_CFG + 12'h010, 32'h10);
		step(4, 1, 3, 1);
		run(600);
		chk(call_out[4], 0);
		print_verdict();
	end
endmodule
